/* src/core_pkg.sv */
// constants, types and state layout of the return-stack and rotate execution unit
// Contract
// RULE_01 - discard opcode drops the return stack top; the next entry becomes top
// RULE_02 - push opcode stores pc plus two on the stack in one cycle
// RULE_03 - relative call carries an 11-bit signed offset under prefix 11011
// RULE_04 - relative call pushes pc plus two, then jumps to that plus twice offset
// RULE_05 - relative call takes two cycles; the second one does nothing
// RULE_06 - software reset starts in phase two and resets like master clear
// RULE_07 - interrupt return pops into pc, sets one global enable, two cycles
// RULE_08 - fast bit set restores working, flag and bank from the shadows
// RULE_09 - literal return loads working with the literal and pops pc, two cycles
// RULE_10 - returns leave the pc high and upper latches unchanged
// RULE_11 - subroutine return pops pc in two cycles, restores shadows on fast bit
// RULE_12 - rotate through carry: bit 7 to carry, carry to bit 0, sets C N Z
// RULE_13 - plain rotate: bit 7 to bit 0, carry kept, sets N and Z only
// RULE_14 - destination bit zero writes working, one writes the file register
// RULE_15 - access bit zero uses the access bank, one uses the bank select
// RULE_16 - access zero, extended set on, address at most 95: indexed offset mode
// RULE_17 - one-cycle ops; rotates read in phase two and write in phase four
package core_pkg;

    // ************************************************************
    // register map, byte addresses
    // ************************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_OPCODE = 8'h04;
    localparam logic [7:0] REG_STATE = 8'h08;
    localparam logic [7:0] REG_PC = 8'h0C;
    localparam logic [7:0] REG_W = 8'h10;
    localparam logic [7:0] REG_BSR = 8'h14;
    localparam logic [7:0] REG_FLAGS = 8'h18;
    localparam logic [7:0] REG_SHADOW = 8'h1C;
    localparam logic [7:0] REG_LATCH = 8'h20;
    localparam logic [7:0] REG_INDEX = 8'h24;
    localparam logic [7:0] REG_IRQ = 8'h28;
    localparam logic [7:0] REG_FILE_ADDR = 8'h2C;
    localparam logic [7:0] REG_FILE_DATA = 8'h30;
    localparam logic [7:0] REG_STACK = 8'h34;

    // ************************************************************
    // opcodes and fields
    // ************************************************************
    localparam logic [15:0] OP_POP = 16'h0006;
    localparam logic [15:0] OP_PUSH = 16'h0005;
    localparam logic [15:0] OP_RESET = 16'h00FF;
    localparam logic [14:0] OP_RETURN_FROM_INTERRUPT_OP_TOP = 15'h0008;
    localparam logic [14:0] OP_RETURN_TOP = 15'h0009;
    localparam logic [7:0] OP_RETURN_WITH_LITERAL_OP_TOP = 8'h0C;
    localparam logic [4:0] OP_RELATIVE_CALL_OP_TOP = 5'h1B;
    localparam logic [5:0] OP_ROTATE_LEFT_CARRY_OP_TOP = 6'h0D;
    localparam logic [5:0] OP_ROTATE_LEFT_PLAIN_OP_TOP = 6'h11;
    localparam int FIELD_DEST = 9;
    localparam int FIELD_ACCESS = 8;
    localparam int FIELD_FAST = 0;
    localparam logic [7:0] ACCESS_LIMIT = 8'h5F;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

    // ************************************************************
    // flag positions, timing, sizes
    // ************************************************************
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 2;
    localparam int FLAG_N = 4;
    localparam int CTRL_EXT = 0;
    localparam int CTRL_PRIO_LOW = 1;
    localparam logic [1:0] Q_READ = 2'h1;
    localparam logic [1:0] Q_POP = 2'h2;
    localparam logic [1:0] Q_LAST = 2'h3;
    localparam logic [20:0] PC_STEP = 21'h000002;
    localparam int STACK_DEPTH = 31;
    localparam int FILE_AW = 12;

    typedef enum logic [3:0] {
        K_NOP = 4'h0,
        K_POP = 4'h1,
        K_PUSH = 4'h2,
        K_RESET = 4'h3,
        K_RETURN_FROM_INTERRUPT_OP = 4'h4,
        K_RETURN = 4'h5,
        K_RETURN_WITH_LITERAL_OP = 4'h6,
        K_RELATIVE_CALL_OP = 4'h7,
        K_ROTATE_LEFT_CARRY_OP = 4'h8,
        K_ROTATE_LEFT_PLAIN_OP = 4'h9
    } op_kind_e;

    typedef struct packed {
        logic pend;
        logic pend_write;
        logic [5:0] pend_idx;
        logic hready;
        logic hresp;
        logic [31:0] rdata;
    } bus_state_s;

    typedef struct packed {
        bus_state_s bus;
        logic busy;
        logic second;
        logic [1:0] qph;
        logic [15:0] opcode;
        logic [20:0] pc;
        logic [7:0] w;
        logic [4:0] flags;
        logic [3:0] bank_select_register;
        logic [7:0] ws;
        logic [4:0] flags_s;
        logic [3:0] bsr_s;
        logic [7:0] pc_high_latch;
        logic [4:0] pc_upper_latch;
        logic global_irq_enable_high;
        logic global_irq_enable_low;
        logic ext_en;
        logic prio_low;
        logic [11:0] index_base;
        logic [11:0] file_addr;
        logic [4:0] sp;
        logic [7:0] operand;
    } core_state_s;

    // reset value of every field; the bus idles ready
    localparam core_state_s STATE_RESET = '{bus: '{hready: 1'b1, default: '0}, default: '0};

endpackage

/* src/ram_1r1w.sv */
// small memory with one write port and a registered read port
`timescale 1ns/1ns
module ram_1r1w #(
    parameter int W = 8,
    parameter int AW = 5,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [W-1:0] rdata
);
    logic [W-1:0] mem [DEPTH];

    // contents are not cleared by reset, as in a real array
    always_ff @(posedge clk) begin
        if (ce && we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (ce) begin
            rdata <= mem[raddr];
        end
    end
endmodule

/* src/return_stack_and_rotate_ops.sv */
// execution unit for stack, call, return, software reset and rotate-left opcodes
//
// Local design decisions: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module return_stack_and_rotate_ops #(
    parameter int STACK_DEPTH = core_pkg::STACK_DEPTH,
    parameter int FILE_AW = core_pkg::FILE_AW
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);
    core_pkg::core_state_s s;
    core_pkg::core_state_s n;
    core_pkg::core_state_s keep;
    core_pkg::op_kind_e kind;

    logic stk_we;
    logic [4:0] stk_waddr;
    logic [20:0] stk_wdata;
    logic [4:0] stk_raddr;
    logic [20:0] stk_rdata;
    logic [20:0] return_stack_top;
    logic file_we;
    logic [FILE_AW-1:0] file_waddr;
    logic [7:0] file_wdata;
    logic [FILE_AW-1:0] file_raddr;
    logic [7:0] file_rdata;
    logic [FILE_AW-1:0] exec_addr;
    logic [11:0] full_addr;
    logic [7:0] f_addr;
    logic [7:0] result;
    logic [20:0] rel_off;
    logic two_cycle;
    logic is_return;
    logic soft_rst;
    logic [31:0] rd_value;
    logic [7:0] reg_off;

    // ************************************************************
    // decode
    // ************************************************************
    always_comb begin
        kind = core_pkg::K_NOP;
        if (s.opcode == core_pkg::OP_POP) begin
            kind = core_pkg::K_POP; // RULE_01
        end else if (s.opcode == core_pkg::OP_PUSH) begin
            kind = core_pkg::K_PUSH; // RULE_02
        end else if (s.opcode == core_pkg::OP_RESET) begin
            kind = core_pkg::K_RESET; // RULE_06
        end else if (s.opcode[15:1] == core_pkg::OP_RETURN_FROM_INTERRUPT_OP_TOP) begin
            kind = core_pkg::K_RETURN_FROM_INTERRUPT_OP; // RULE_07
        end else if (s.opcode[15:1] == core_pkg::OP_RETURN_TOP) begin
            kind = core_pkg::K_RETURN; // RULE_11
        end else if (s.opcode[15:8] == core_pkg::OP_RETURN_WITH_LITERAL_OP_TOP) begin
            kind = core_pkg::K_RETURN_WITH_LITERAL_OP; // RULE_09
        end else if (s.opcode[15:11] == core_pkg::OP_RELATIVE_CALL_OP_TOP) begin
            kind = core_pkg::K_RELATIVE_CALL_OP; // RULE_03
        end else if (s.opcode[15:10] == core_pkg::OP_ROTATE_LEFT_CARRY_OP_TOP) begin
            kind = core_pkg::K_ROTATE_LEFT_CARRY_OP; // RULE_12
        end else if (s.opcode[15:10] == core_pkg::OP_ROTATE_LEFT_PLAIN_OP_TOP) begin
            kind = core_pkg::K_ROTATE_LEFT_PLAIN_OP; // RULE_13
        end
    end

    assign is_return = (kind == core_pkg::K_RETURN_FROM_INTERRUPT_OP) || (kind == core_pkg::K_RETURN) ||
                       (kind == core_pkg::K_RETURN_WITH_LITERAL_OP);
    assign two_cycle = is_return || (kind == core_pkg::K_RELATIVE_CALL_OP); // RULE_05
    // sign-extended offset, doubled
    assign rel_off = {{9{s.opcode[10]}}, s.opcode[10:0], 1'b0}; // RULE_03

    // ************************************************************
    // file address for the rotates
    // ************************************************************
    assign f_addr = s.opcode[7:0];
    always_comb begin
        if (s.opcode[core_pkg::FIELD_ACCESS]) begin
            full_addr = {s.bank_select_register, f_addr}; // RULE_15
        end else if (s.ext_en && (f_addr <= core_pkg::ACCESS_LIMIT)) begin
            full_addr = s.index_base + {4'h0, f_addr}; // RULE_16
        end else if (f_addr <= core_pkg::ACCESS_LIMIT) begin
            full_addr = {4'h0, f_addr}; // RULE_15
        end else begin
            full_addr = {core_pkg::ACCESS_HIGH_BANK, f_addr}; // RULE_15
        end
    end
    assign exec_addr = full_addr[FILE_AW-1:0];
    // while busy the read port belongs to the opcode, so bus reads of file data return the opcode's file register
    assign file_raddr = s.busy ? exec_addr : s.file_addr[FILE_AW-1:0];

    // ************************************************************
    // return stack
    // ************************************************************
    assign stk_raddr = (s.sp == 5'h00) ? 5'h00 : s.sp - 5'h01;
    assign return_stack_top = (s.sp == 5'h00) ? 21'h000000 : stk_rdata;

    ram_1r1w #(.W(21), .AW(5), .DEPTH(STACK_DEPTH)) u_stack (
        .clk(hclk),
        .rst_n(hresetn),
        .ce(ce),
        .we(stk_we),
        .waddr(stk_waddr),
        .wdata(stk_wdata),
        .raddr(stk_raddr),
        .rdata(stk_rdata)
    );

    ram_1r1w #(.W(8), .AW(FILE_AW), .DEPTH(2 ** FILE_AW)) u_file (
        .clk(hclk),
        .rst_n(hresetn),
        .ce(ce),
        .we(file_we),
        .waddr(file_waddr),
        .wdata(file_wdata),
        .raddr(file_raddr),
        .rdata(file_rdata)
    );

    // ************************************************************
    // rotate data path
    // ************************************************************
    always_comb begin
        if (kind == core_pkg::K_ROTATE_LEFT_CARRY_OP) begin
            result = {s.operand[6:0], s.flags[core_pkg::FLAG_C]}; // RULE_12
        end else begin
            result = {s.operand[6:0], s.operand[7]}; // RULE_13
        end
    end

    // ************************************************************
    // register read mux
    // ************************************************************
    assign reg_off = {s.bus.pend_idx, 2'b00};
    always_comb begin
        rd_value = 32'h00000000;
        unique case (reg_off)
            core_pkg::REG_CTRL: rd_value = {30'h00000000, s.prio_low, s.ext_en};
            core_pkg::REG_OPCODE: rd_value = {16'h0000, s.opcode};
            core_pkg::REG_STATE: rd_value = {19'h00000, s.sp, 4'h0, s.qph, s.second, s.busy};
            core_pkg::REG_PC: rd_value = {11'h000, s.pc};
            core_pkg::REG_W: rd_value = {24'h000000, s.w};
            core_pkg::REG_BSR: rd_value = {28'h0000000, s.bank_select_register};
            core_pkg::REG_FLAGS: rd_value = {27'h0000000, s.flags};
            core_pkg::REG_SHADOW: rd_value = {12'h000, s.bsr_s, 3'h0, s.flags_s, s.ws};
            core_pkg::REG_LATCH: rd_value = {11'h000, s.pc_upper_latch, 8'h00, s.pc_high_latch};
            core_pkg::REG_INDEX: rd_value = {20'h00000, s.index_base};
            core_pkg::REG_IRQ: rd_value = {30'h00000000, s.global_irq_enable_low,
                                           s.global_irq_enable_high};
            core_pkg::REG_FILE_ADDR: rd_value = {20'h00000, s.file_addr};
            core_pkg::REG_FILE_DATA: rd_value = {24'h000000, file_rdata};
            core_pkg::REG_STACK: rd_value = {11'h000, return_stack_top};
            default: rd_value = 32'h00000000;
        endcase
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        n = s;
        keep = s;
        stk_we = 1'b0;
        stk_waddr = s.sp;
        stk_wdata = s.pc + core_pkg::PC_STEP;
        file_we = 1'b0;
        file_waddr = exec_addr;
        file_wdata = result;
        soft_rst = 1'b0;

        // bus data phase: one wait state, then the answer
        if (s.bus.pend) begin
            n.bus.pend = 1'b0;
            n.bus.hready = 1'b1;
            n.bus.rdata = s.bus.pend_write ? 32'h00000000 : rd_value;
            // software writes are dropped while an opcode runs
            if (s.bus.pend_write && !s.busy) begin
                unique case (reg_off)
                    core_pkg::REG_CTRL: begin
                        n.ext_en = hwdata[core_pkg::CTRL_EXT];
                        n.prio_low = hwdata[core_pkg::CTRL_PRIO_LOW];
                    end
                    core_pkg::REG_OPCODE: begin
                        n.opcode = hwdata[15:0];
                        n.busy = 1'b1;
                        n.second = 1'b0;
                        n.qph = 2'h0;
                    end
                    core_pkg::REG_PC: n.pc = {hwdata[20:1], 1'b0};
                    core_pkg::REG_W: n.w = hwdata[7:0];
                    core_pkg::REG_BSR: n.bank_select_register = hwdata[3:0];
                    core_pkg::REG_FLAGS: n.flags = hwdata[4:0];
                    core_pkg::REG_SHADOW: begin
                        n.ws = hwdata[7:0];
                        n.flags_s = hwdata[12:8];
                        n.bsr_s = hwdata[19:16];
                    end
                    core_pkg::REG_LATCH: begin
                        n.pc_high_latch = hwdata[7:0];
                        n.pc_upper_latch = hwdata[20:16];
                    end
                    core_pkg::REG_INDEX: n.index_base = hwdata[11:0];
                    core_pkg::REG_IRQ: begin
                        n.global_irq_enable_high = hwdata[0];
                        n.global_irq_enable_low = hwdata[1];
                    end
                    core_pkg::REG_FILE_ADDR: n.file_addr = hwdata[11:0];
                    core_pkg::REG_FILE_DATA: begin
                        file_we = 1'b1;
                        file_waddr = s.file_addr[FILE_AW-1:0];
                        file_wdata = hwdata[7:0];
                    end
                    default: n.bus.hresp = 1'b0;
                endcase
            end
        end

        // bus address phase
        if (hsel && hready && htrans[1]) begin
            n.bus.pend = 1'b1;
            n.bus.pend_write = hwrite;
            n.bus.pend_idx = haddr[7:2];
            n.bus.hready = 1'b0;
        end

        // instruction cycle: four quarter phases per cycle
        if (s.busy) begin
            n.qph = s.qph + 2'h1;
            if (!s.second) begin
                unique case (kind)
                    core_pkg::K_PUSH, core_pkg::K_RELATIVE_CALL_OP: begin
                        if (s.qph == core_pkg::Q_READ && s.sp < 5'(STACK_DEPTH)) begin
                            stk_we = 1'b1; // RULE_02 RULE_04
                            n.sp = s.sp + 5'h01;
                        end
                        if (s.qph == core_pkg::Q_LAST && kind == core_pkg::K_RELATIVE_CALL_OP) begin
                            n.pc = s.pc + core_pkg::PC_STEP + rel_off; // RULE_04
                        end
                    end
                    core_pkg::K_POP: begin
                        if (s.qph == core_pkg::Q_POP && s.sp != 5'h00) begin
                            n.sp = s.sp - 5'h01; // RULE_01
                        end
                    end
                    core_pkg::K_RESET: begin
                        if (s.qph == core_pkg::Q_READ) begin
                            soft_rst = 1'b1; // RULE_06
                        end
                    end
                    core_pkg::K_RETURN_FROM_INTERRUPT_OP, core_pkg::K_RETURN, core_pkg::K_RETURN_WITH_LITERAL_OP: begin
                        if (s.qph == core_pkg::Q_LAST) begin
                            // only the counter moves; both latches keep their value
                            n.pc = return_stack_top; // RULE_07 RULE_09 RULE_10 RULE_11
                            if (s.sp != 5'h00) begin
                                n.sp = s.sp - 5'h01;
                            end
                            if (kind == core_pkg::K_RETURN_WITH_LITERAL_OP) begin
                                n.w = s.opcode[7:0]; // RULE_09
                            end else if (s.opcode[core_pkg::FIELD_FAST]) begin
                                n.w = s.ws; // RULE_08 RULE_11
                                n.flags = s.flags_s;
                                n.bank_select_register = s.bsr_s;
                            end
                            if (kind == core_pkg::K_RETURN_FROM_INTERRUPT_OP) begin
                                if (s.prio_low) begin
                                    n.global_irq_enable_low = 1'b1; // RULE_07
                                end else begin
                                    n.global_irq_enable_high = 1'b1; // RULE_07
                                end
                            end
                        end
                    end
                    core_pkg::K_ROTATE_LEFT_CARRY_OP, core_pkg::K_ROTATE_LEFT_PLAIN_OP: begin
                        if (s.qph == core_pkg::Q_READ) begin
                            n.operand = file_rdata; // RULE_17
                        end
                        if (s.qph == core_pkg::Q_LAST) begin
                            if (s.opcode[core_pkg::FIELD_DEST]) begin
                                file_we = 1'b1; // RULE_14 RULE_17
                            end else begin
                                n.w = result; // RULE_14
                            end
                            if (kind == core_pkg::K_ROTATE_LEFT_CARRY_OP) begin
                                n.flags[core_pkg::FLAG_C] = s.operand[7]; // RULE_12
                            end
                            n.flags[core_pkg::FLAG_N] = result[7]; // RULE_12 RULE_13
                            n.flags[core_pkg::FLAG_Z] = (result == 8'h00);
                        end
                    end
                    core_pkg::K_NOP: n.operand = s.operand;
                endcase
                if (s.qph == core_pkg::Q_LAST && !two_cycle) begin
                    n.pc = s.pc + core_pkg::PC_STEP; // RULE_17
                end
            end
            if (s.qph == core_pkg::Q_LAST) begin
                if (two_cycle && !s.second) begin
                    n.second = 1'b1; // RULE_05
                end else begin
                    n.busy = 1'b0;
                    n.second = 1'b0;
                end
            end
        end

        // software reset clears the core as master clear does, but a bus transfer survives
        if (soft_rst) begin
            keep = n;
            n = core_pkg::STATE_RESET; // RULE_06
            n.bus = keep.bus;
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= core_pkg::STATE_RESET;
        end else if (ce) begin
            s <= n;
        end
    end

    assign hreadyout = s.bus.hready;
    assign hresp = s.bus.hresp;
    assign hrdata = s.bus.rdata;
endmodule

/* testbench/rsr_bus_checker_properties.sv */
// bus-side properties of the return-stack and rotate execution unit
`timescale 1ns/1ns
module rsr_bus_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata
);
    // ************************************************************
    // handshake and read data
    // ************************************************************
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire logic acc = hsel && hready && htrans[1] && ce;
    sequence taken_s;
        acc;
    endsequence
    sequence answer_s;
        !hreadyout ##1 hreadyout;
    endsequence
    okay_resp_a: assert property (hresp == 1'b0) else $error("response not okay");
    one_wait_a: assert property (taken_s |=> answer_s) else $error("wait state not one cycle");
    no_stall_a: assert property (!hreadyout |=> hreadyout) else $error("wait state too long");
    wait_cause_a: assert property ($fell(hreadyout) |-> $past(acc))
        else $error("wait state without request");
    write_zero_a: assert property ((acc && hwrite ##1 answer_s) |-> hrdata == 32'h0)
        else $error("read data not cleared by write");
    // read data must not drift between transfers, software polls it
    rdata_hold_a: assert property ($stable(hrdata) || $rose(hreadyout))
        else $error("read data changed outside completion");
    unmapped_zero_a: assert property ((acc && !hwrite && haddr[7:2] > 6'h0D ##1 answer_s)
        |-> hrdata == 32'h0) else $error("unmapped read not zero");
    reset_idle_a: assert property ($rose(hresetn) |-> hreadyout && hrdata == 32'h0)
        else $error("bus not idle after reset");
endmodule

/* testbench/return_stack_and_rotate_ops_tb.sv */
// self-checking bench for the return-stack and rotate execution unit
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module return_stack_and_rotate_ops_tb;
    typedef struct packed {
        logic [15:0] op;
        logic [7:0] ctrl;
        logic [11:0] addr;
        logic [7:0] init, flg, ew, ef, eflg;
    } rot_row_s;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ce = 1'b1;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
    wire logic hreadyout, hresp;
    wire logic [31:0] hrdata;
    int err_count = 0, total_checks = 0;
    rot_row_s rows [5] = '{
        '{16'h3620, 8'h00, 12'h020, 8'hE6, 8'h00, 8'h00, 8'hCC, 8'h11},
        '{16'h3420, 8'h00, 12'h020, 8'hE6, 8'h01, 8'hCD, 8'hE6, 8'h11},
        '{16'h4720, 8'h00, 12'h220, 8'hAB, 8'h01, 8'h00, 8'h57, 8'h01},
        '{16'h4480, 8'h00, 12'hF80, 8'h00, 8'h10, 8'h00, 8'h00, 8'h04},
        '{16'h3620, 8'h01, 12'h120, 8'h80, 8'h00, 8'h00, 8'h00, 8'h05}};
    always #4 hclk = ~hclk;
    return_stack_and_rotate_ops return_stack_and_rotate_ops_inst (.hclk(hclk), .hresetn(hresetn),
        .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata));
    // ************************************************************
    // bus tasks: entered right after a rising edge
    // ************************************************************
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask
    // polling busy rather than counting clocks keeps the bench timing-agnostic
    task automatic exec(input logic [15:0] op);
        wr(core_pkg::REG_OPCODE, 32'(op));
        do xfer(1'b0, core_pkg::REG_STATE, 32'h0); while (q[0] !== 1'b0);
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        give_verdict();
    end
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(core_pkg::REG_STATE, 32'h0);
        wr(core_pkg::REG_BSR, 32'h2);
        wr(core_pkg::REG_INDEX, 32'h100);
        foreach (rows[i]) begin
            wr(core_pkg::REG_FILE_ADDR, 32'(rows[i].addr));
            wr(core_pkg::REG_FILE_DATA, 32'(rows[i].init));
            wr(core_pkg::REG_W, 32'h0);
            wr(core_pkg::REG_FLAGS, 32'(rows[i].flg));
            wr(core_pkg::REG_CTRL, 32'(rows[i].ctrl));
            exec(rows[i].op);
            rd(core_pkg::REG_W, 32'(rows[i].ew));
            rd(core_pkg::REG_FILE_DATA, 32'(rows[i].ef));
            rd(core_pkg::REG_FLAGS, 32'(rows[i].eflg));
        end
        wr(core_pkg::REG_CTRL, 32'h0);
        wr(core_pkg::REG_PC, 32'h124);
        exec(core_pkg::OP_PUSH);
        rd(core_pkg::REG_STACK, 32'h126);
        exec(core_pkg::OP_PUSH);
        rd(core_pkg::REG_STACK, 32'h128);
        exec(core_pkg::OP_POP);
        rd(core_pkg::REG_STACK, 32'h126);
        wr(core_pkg::REG_PC, 32'h1000);
        exec(16'hDC00);
        rd(core_pkg::REG_STACK, 32'h1002);
        rd(core_pkg::REG_PC, 32'h802);
        wr(core_pkg::REG_OPCODE, 32'hDFFF);
        rd(core_pkg::REG_STATE, 32'h309);
        rd(core_pkg::REG_STATE, 32'h307);
        rd(core_pkg::REG_STATE, 32'h300);
        rd(core_pkg::REG_PC, 32'h802);
        wr(core_pkg::REG_SHADOW, 32'h3155A);
        wr(core_pkg::REG_LATCH, 32'h120034);
        exec(16'h0013);
        rd(core_pkg::REG_PC, 32'h804);
        rd(core_pkg::REG_W, 32'h5A);
        rd(core_pkg::REG_FLAGS, 32'h15);
        rd(core_pkg::REG_BSR, 32'h3);
        exec(16'h0CA7);
        rd(core_pkg::REG_W, 32'hA7);
        rd(core_pkg::REG_PC, 32'h1002);
        exec(16'h0010);
        rd(core_pkg::REG_PC, 32'h126);
        rd(core_pkg::REG_IRQ, 32'h1);
        rd(core_pkg::REG_W, 32'hA7);
        wr(core_pkg::REG_CTRL, 32'h2);
        exec(core_pkg::OP_PUSH);
        exec(16'h0011);
        rd(core_pkg::REG_IRQ, 32'h3);
        rd(core_pkg::REG_W, 32'h5A);
        rd(core_pkg::REG_LATCH, 32'h120034);
        exec(core_pkg::OP_RESET);
        rd(core_pkg::REG_PC, 32'h0);
        rd(core_pkg::REG_IRQ, 32'h0);
        rd(core_pkg::REG_STACK, 32'h0);
        rd(core_pkg::REG_W, 32'h0);
        // a low enable must hold the opcode mid-cycle, push included
        wr(core_pkg::REG_OPCODE, 32'(core_pkg::OP_PUSH));
        ce <= 1'b0;
        repeat (8) @(posedge hclk);
        ce <= 1'b1;
        rd(core_pkg::REG_STATE, 32'h109);
        do xfer(1'b0, core_pkg::REG_STATE, 32'h0); while (q[0] !== 1'b0);
        wr(8'h3C, 32'hFFFF);
        rd(8'h3C, 32'h0);
        give_verdict();
    end
endmodule
bind return_stack_and_rotate_ops rsr_bus_checker rsr_bus_checker_inst (.hclk(hclk),
    .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata));
